//--- logic/pmsb_pkg.sv
// Purpose: shared constants for the power-management register bank
// Assumes: 8-bit register bus of the embedded core, byte offsets fixed by the core map
// Notes: the scratch and identity-free bank has no type beyond the unlock states
package pmsb_pkg;

  // register offsets on the core register bus
  localparam logic [7:0] PMSB_OFS_KEY = 8'hC1;
  localparam logic [7:0] PMSB_OFS_POWER_CONTROL = 8'hC5;
  localparam logic [7:0] PMSB_OFS_IRQ_ENABLE = 8'hEC;
  localparam logic [7:0] PMSB_OFS_EVENT_FLAGS = 8'hF8;
  localparam logic [7:0] PMSB_OFS_SCRATCH_A = 8'hFB;
  localparam logic [7:0] PMSB_OFS_SCRATCH_B = 8'hFC;
  localparam logic [7:0] PMSB_OFS_SCRATCH_C = 8'hFD;
  localparam logic [7:0] PMSB_OFS_SCRATCH_D = 8'hFE;

  // unlock value that must precede every power control write
  localparam logic [7:0] PMSB_KEY_UNLOCK = 8'hA7;

  // interrupt enable and event flag bit positions (shared layout)
  localparam int PMSB_BIT_SUPPLY_RESTORED = 7;
  localparam int PMSB_BIT_IRQ_SUMMARY = 6;
  localparam int PMSB_BIT_VOLTAGE_DIP = 5;
  localparam int PMSB_BIT_RESERVED_4 = 4;
  localparam int PMSB_BIT_DC_INPUT_CONV = 3;
  localparam int PMSB_BIT_BATTERY_MONITOR = 2;
  localparam int PMSB_BIT_SWITCHOVER = 1;
  localparam int PMSB_BIT_DC_INPUT_LOW = 0;

  // bits of the enable register that hold state; bit 6 reads zero
  localparam logic [7:0] PMSB_IRQ_ENABLE_MASK = 8'hBF;
  // event bits that hardware can set
  localparam logic [7:0] PMSB_EVENT_MASK = 8'hAF;
  localparam logic [7:0] PMSB_IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PMSB_EVENT_FLAGS_RESET = 8'h00;

  // power control fields
  localparam int PMSB_BIT_PC_RESERVED_7 = 7;
  localparam int PMSB_BIT_METERING_POWER_DOWN = 6;
  localparam int PMSB_BIT_PC_RESERVED_5 = 5;
  localparam int PMSB_BIT_PROCESSOR_SHUTDOWN = 4;
  localparam int PMSB_CD_LSB = 0;
  localparam int PMSB_CD_WIDTH = 3;
  localparam logic [2:0] PMSB_CD_RESET = 3'h2;
  localparam logic PMSB_PC_RESERVED_7_RESET = 1'b1;

  localparam logic [7:0] PMSB_SCRATCH_RESET = 8'h00;
  localparam logic [7:0] PMSB_UNMAPPED_READ = 8'h00;

  // source frequency of the core clock divider, in kHz
  localparam int PMSB_CORE_SRC_KHZ = 4096;

  typedef enum logic [1:0] {
    PMSB_LOCKED = 2'b01,
    PMSB_UNLOCKED = 2'b10
  } pmsb_key_state_t;

endpackage : pmsb_pkg

//--- logic/pmsb_retained_reg.sv
// Purpose: one 8-bit scratch register that survives every power-saving mode
// Assumes: clear comes from the loss of both supplies, already synchronised
// Notes: the ordinary system reset is deliberately not connected here
`timescale 1ns/10ps
module pmsb_retained_reg
  import pmsb_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and retention clear
  input wire logic clk,
  input wire logic clear,
  // write port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // stored value
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_r;

  always_ff @(posedge clk) begin
    if (clear) begin
      value_r <= WIDTH'(PMSB_SCRATCH_RESET);
    end else if (wr_en) begin
      value_r <= wr_data;
    end
  end

  assign value = value_r;

endmodule : pmsb_retained_reg

//--- logic/pmsb_core_clk_div.sv
// Purpose: core clock enable, source tick divided by two to the power of sel
// Assumes: src_tick is a one-cycle enable at the divider source rate
// Notes: a new setting is only taken at the end of a whole divided period
`timescale 1ns/10ps
module pmsb_core_clk_div
  import pmsb_pkg::*;
#(
  parameter int SEL_WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // source rate and requested divider
  input wire logic src_tick,
  input wire logic [SEL_WIDTH-1:0] div_sel,
  // divided enable and divider in force
  output logic core_tick,
  output logic [SEL_WIDTH-1:0] sel_applied
);

  localparam int CNT_W = (1 << SEL_WIDTH) - 1;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [SEL_WIDTH-1:0] sel_r;
  logic tick_r;
  logic [CNT_W-1:0] last_count;
  logic period_end;

  // terminal count for the divider now in force
  assign last_count = CNT_W'((CNT_W'(1) << sel_r) - CNT_W'(1));
  assign period_end = src_tick && (cnt_r == last_count);
  assign cnt_nxt = period_end ? '0 : CNT_W'(cnt_r + CNT_W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      sel_r <= SEL_WIDTH'(PMSB_CD_RESET);
      tick_r <= 1'b0;
    end else begin
      tick_r <= period_end;
      if (src_tick) begin
        cnt_r <= cnt_nxt;
      end
      // switching only at a period boundary keeps every pulse whole
      if (period_end) begin
        sel_r <= div_sel;
      end
    end
  end

  assign core_tick = tick_r;
  assign sel_applied = sel_r;

endmodule : pmsb_core_clk_div

//--- logic/pmsb_bank.sv
// Purpose: power-management register bank on the core register bus
// Assumes: bus strobes and data are on CLK_SYS; monitor events and supply-loss come from pins
// Notes: scratch registers ignore RESET and clear only on loss of both supplies
//
// Notes on behaviour
// - supply-restored flag with enable bit 7 requests the shared interrupt.
// - voltage-dip flag with enable bit 5 requests the shared interrupt.
// - dc-input converter flag with enable bit 3 requests the interrupt.
// - battery monitor flag with enable bit 2 requests the interrupt.
// - switchover flag with enable bit 1 requests the interrupt.
// - dc-input low flag with enable bit 0 requests the interrupt.
// - four 8-bit scratch registers are read/write and survive power-saving modes.
// - scratch registers clear only when both supplies are lost.
// - power control bit 6 switches off metering modulators and signal processing.
// - bit 4 in battery run mode shuts down core, entering sleep mode.
// - divider field gives 4.096 MHz over two to the field; resets to 010.
// - event flags set on their event regardless of enables.
// - flags stay latched until software writes zero to them.
// - one shared interrupt, gated by master enable from the core.
`timescale 1ns/10ps
module pmsb_bank
  import pmsb_pkg::*;
#(
  parameter int NUM_EVENTS = 8,
  parameter int CD_WIDTH = 3
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // core register bus
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  // power-state context from the supply management
  input wire logic BATTERY_RUN_MODE,
  input wire logic SUPPLY_IRQ_MASTER_EN,
  input wire logic BOTH_SUPPLIES_LOST,
  // monitor events, one bit per flag position
  input wire logic [NUM_EVENTS-1:0] SUPPLY_EVENT_IN,
  // divider source rate
  input wire logic CORE_SRC_TICK,
  // controls and interrupt
  output logic METERING_POWER_DOWN,
  output logic PROCESSOR_SHUTDOWN,
  output logic CORE_CLK_EN,
  output logic [CD_WIDTH-1:0] CORE_CLOCK_DIVIDER,
  output logic SUPPLY_IRQ
);

  // register state
  logic [7:0] irq_enable_r;
  logic [7:0] irq_enable_nxt;
  logic [7:0] event_flags_r;
  logic [7:0] event_flags_nxt;
  logic metering_power_down_r;
  logic processor_shutdown_r;
  logic [CD_WIDTH-1:0] core_clock_divider_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic shutdown_out_r;
  pmsb_key_state_t key_state_r;
  pmsb_key_state_t key_state_nxt;

  // pin synchronisers
  logic [NUM_EVENTS-1:0] evt_meta_r;
  logic [NUM_EVENTS-1:0] evt_sync_r;
  logic [NUM_EVENTS-1:0] evt_prev_r;
  logic lost_meta_r;
  logic lost_sync_r;

  // decode
  logic wr_key;
  logic wr_power_control;
  logic wr_irq_enable;
  logic wr_event_flags;
  logic pc_write_ok;
  logic [3:0] wr_scratch;
  logic [7:0] scratch_q [4];
  logic [7:0] power_control_view;
  logic [7:0] event_rise;
  logic [7:0] pending;
  logic irq_nxt;
  logic core_tick;
  logic [CD_WIDTH-1:0] cd_applied;
  logic shutdown_nxt;

  // unlock decode
  logic key_match;
  logic key_relock;

  // power control next values
  logic metering_power_down_nxt;
  logic processor_shutdown_nxt;
  logic [CD_WIDTH-1:0] core_clock_divider_nxt;
  logic shutdown_out_nxt;

  // one request term per source
  logic req_supply_restored;
  logic req_voltage_dip;
  logic req_dc_input_conv;
  logic req_battery_monitor;
  logic req_switchover;
  logic req_dc_input_low;
  logic pending_any;

  // read selects
  logic rd_sel_power_control;
  logic rd_sel_irq_enable;
  logic rd_sel_event_flags;
  logic rd_sel_scratch_a;
  logic rd_sel_scratch_b;
  logic rd_sel_scratch_c;
  logic rd_sel_scratch_d;
  logic [7:0] event_flags_view;

  // events and supply loss come from the analog side: two stages before use
  always_ff @(posedge CLK_SYS) begin
    evt_meta_r <= SUPPLY_EVENT_IN;
    evt_sync_r <= evt_meta_r;
    evt_prev_r <= evt_sync_r;
    lost_meta_r <= BOTH_SUPPLIES_LOST;
    lost_sync_r <= lost_meta_r;
  end

  // a level held by a monitor counts once, on its rising edge
  // the edge stage follows the synced level through reset too, so no false edge follows it
  assign event_rise = 8'(evt_sync_r & ~evt_prev_r) & PMSB_EVENT_MASK;

  // address decode
  assign wr_key = SFR_WR && (SFR_ADDR == PMSB_OFS_KEY);
  assign wr_power_control = SFR_WR && (SFR_ADDR == PMSB_OFS_POWER_CONTROL);
  assign wr_irq_enable = SFR_WR && (SFR_ADDR == PMSB_OFS_IRQ_ENABLE);
  assign wr_event_flags = SFR_WR && (SFR_ADDR == PMSB_OFS_EVENT_FLAGS);
  assign wr_scratch[0] = SFR_WR && (SFR_ADDR == PMSB_OFS_SCRATCH_A);
  assign wr_scratch[1] = SFR_WR && (SFR_ADDR == PMSB_OFS_SCRATCH_B);
  assign wr_scratch[2] = SFR_WR && (SFR_ADDR == PMSB_OFS_SCRATCH_C);
  assign wr_scratch[3] = SFR_WR && (SFR_ADDR == PMSB_OFS_SCRATCH_D);

  // unlock: key write arms, the next register write other than a repeated key consumes it
  assign key_match = wr_key && (SFR_WDATA == PMSB_KEY_UNLOCK);
  // a repeated key keeps the lock open; every other write closes it
  assign key_relock = SFR_WR && !key_match;
  assign pc_write_ok = wr_power_control && (key_state_r == PMSB_UNLOCKED);

  always_comb begin
    key_state_nxt = key_state_r;
    unique case (key_state_r)
      PMSB_LOCKED: begin
        // only the exact key value arms; other key writes are ignored
        if (key_match) begin
          key_state_nxt = PMSB_UNLOCKED;
        end
      end
      PMSB_UNLOCKED: begin
        // any other write, the intended one included, locks again
        if (key_relock) begin
          key_state_nxt = PMSB_LOCKED;
        end
      end
      default: key_state_nxt = PMSB_LOCKED;
    endcase
  end

  // enable register: bit 6 holds nothing, bit 4 is stored but drives nothing
  assign irq_enable_nxt = wr_irq_enable ? (SFR_WDATA & PMSB_IRQ_ENABLE_MASK) : irq_enable_r;

  // a read leaves the flags alone; only a written zero clears them
  // flags: writing zero clears, a same-cycle event wins over the clear
  assign event_flags_nxt = wr_event_flags ?
                           ((event_flags_r & SFR_WDATA) | event_rise) :
                           (event_flags_r | event_rise);

  // every enabled flag feeds the one shared request; bit 4 never takes part
  assign pending = event_flags_r & irq_enable_r & PMSB_EVENT_MASK;
  assign req_supply_restored = pending[PMSB_BIT_SUPPLY_RESTORED];
  assign req_voltage_dip = pending[PMSB_BIT_VOLTAGE_DIP];
  assign req_dc_input_conv = pending[PMSB_BIT_DC_INPUT_CONV];
  assign req_battery_monitor = pending[PMSB_BIT_BATTERY_MONITOR];
  assign req_switchover = pending[PMSB_BIT_SWITCHOVER];
  assign req_dc_input_low = pending[PMSB_BIT_DC_INPUT_LOW];
  // one shared vector, so the core must read the flags to tell sources apart
  assign pending_any = req_supply_restored || req_voltage_dip || req_dc_input_conv ||
                       req_battery_monitor || req_switchover || req_dc_input_low;
  assign irq_nxt = SUPPLY_IRQ_MASTER_EN && pending_any;

  // core shutdown only has effect from the battery run mode
  assign shutdown_nxt = processor_shutdown_r && BATTERY_RUN_MODE;
  // once asleep the core only returns through RESET, so the request holds
  assign shutdown_out_nxt = shutdown_out_r || shutdown_nxt;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      key_state_r <= PMSB_LOCKED;
      irq_enable_r <= PMSB_IRQ_ENABLE_RESET;
      event_flags_r <= PMSB_EVENT_FLAGS_RESET;
      irq_r <= 1'b0;
    end else begin
      key_state_r <= key_state_nxt;
      irq_enable_r <= irq_enable_nxt;
      event_flags_r <= event_flags_nxt;
      irq_r <= irq_nxt;
    end
  end

  // power control register, written only through the unlock sequence
  assign metering_power_down_nxt = pc_write_ok ? SFR_WDATA[PMSB_BIT_METERING_POWER_DOWN] :
                                   metering_power_down_r;
  assign processor_shutdown_nxt = pc_write_ok ? SFR_WDATA[PMSB_BIT_PROCESSOR_SHUTDOWN] :
                                  processor_shutdown_r;
  assign core_clock_divider_nxt = pc_write_ok ? SFR_WDATA[PMSB_CD_LSB +: CD_WIDTH] :
                                  core_clock_divider_r;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      metering_power_down_r <= 1'b0;
      processor_shutdown_r <= 1'b0;
      core_clock_divider_r <= CD_WIDTH'(PMSB_CD_RESET);
      shutdown_out_r <= 1'b0;
    end else begin
      metering_power_down_r <= metering_power_down_nxt;
      processor_shutdown_r <= processor_shutdown_nxt;
      core_clock_divider_r <= core_clock_divider_nxt;
      shutdown_out_r <= shutdown_out_nxt;
    end
  end

  // bit 7 reads its fixed one, bits 5 and 3 read zero whatever was written
  assign power_control_view = {PMSB_PC_RESERVED_7_RESET, metering_power_down_r, 1'b0,
                               processor_shutdown_r, 1'b0, core_clock_divider_r};

  // retained scratch registers, reset only by loss of both supplies
  // RESET is left off these on purpose: software state must outlive a wake-up
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_scratch
      pmsb_retained_reg #(
        .WIDTH(8)
      ) u_scratch (
        .clk(CLK_SYS),
        .clear(lost_sync_r),
        .wr_en(wr_scratch[gi]),
        .wr_data(SFR_WDATA),
        .value(scratch_q[gi])
      );
    end
  endgenerate

  // core clock enable from the 4.096 MHz source tick
  pmsb_core_clk_div #(
    .SEL_WIDTH(CD_WIDTH)
  ) u_clk_div (
    .clk(CLK_SYS),
    .rst(RESET),
    .src_tick(CORE_SRC_TICK),
    .div_sel(core_clock_divider_r),
    .core_tick(core_tick),
    .sel_applied(cd_applied)
  );

  // read selects and mux; the flag register shows the shared request in bit 6
  assign rd_sel_power_control = (SFR_ADDR == PMSB_OFS_POWER_CONTROL);
  assign rd_sel_irq_enable = (SFR_ADDR == PMSB_OFS_IRQ_ENABLE);
  assign rd_sel_event_flags = (SFR_ADDR == PMSB_OFS_EVENT_FLAGS);
  assign rd_sel_scratch_a = (SFR_ADDR == PMSB_OFS_SCRATCH_A);
  assign rd_sel_scratch_b = (SFR_ADDR == PMSB_OFS_SCRATCH_B);
  assign rd_sel_scratch_c = (SFR_ADDR == PMSB_OFS_SCRATCH_C);
  assign rd_sel_scratch_d = (SFR_ADDR == PMSB_OFS_SCRATCH_D);
  // the summary bit is live and not gated by the master enable
  assign event_flags_view = (event_flags_r & PMSB_EVENT_MASK) |
                            (8'(pending_any) << PMSB_BIT_IRQ_SUMMARY);
  assign rdata_nxt = rd_sel_power_control ? power_control_view :
                     rd_sel_irq_enable ? irq_enable_r :
                     rd_sel_event_flags ? event_flags_view :
                     rd_sel_scratch_a ? scratch_q[0] :
                     rd_sel_scratch_b ? scratch_q[1] :
                     rd_sel_scratch_c ? scratch_q[2] :
                     rd_sel_scratch_d ? scratch_q[3] :
                     PMSB_UNMAPPED_READ;

  // read data is held between reads so the core may sample late
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_r <= PMSB_UNMAPPED_READ;
    end else if (SFR_RD) begin
      rdata_r <= rdata_nxt;
    end
  end

  // every output is a flop, here or inside the divider
  assign SFR_RDATA = rdata_r;
  assign METERING_POWER_DOWN = metering_power_down_r;
  assign PROCESSOR_SHUTDOWN = shutdown_out_r;
  assign CORE_CLK_EN = core_tick;
  assign CORE_CLOCK_DIVIDER = cd_applied;
  assign SUPPLY_IRQ = irq_r;

endmodule : pmsb_bank

//--- dv/pmsb_bank_asserts.sv
// Purpose: port-level checks for the power-management register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound into every bank instance
`timescale 1ns/10ps
module pmsb_bank_asserts
  import pmsb_pkg::*;
#(
  parameter int CD_WIDTH = 3
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // register bus
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  // context and outputs
  input wire logic BATTERY_RUN_MODE,
  input wire logic SUPPLY_IRQ_MASTER_EN,
  input wire logic CORE_SRC_TICK,
  input wire logic METERING_POWER_DOWN,
  input wire logic PROCESSOR_SHUTDOWN,
  input wire logic CORE_CLK_EN,
  input wire logic [CD_WIDTH-1:0] CORE_CLOCK_DIVIDER,
  input wire logic SUPPLY_IRQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  sequence rd_pc_s;
    SFR_RD && SFR_ADDR == PMSB_OFS_POWER_CONTROL;
  endsequence
  sequence pc_word_s;
    SFR_RDATA[7] && SFR_RDATA[6] == METERING_POWER_DOWN;
  endsequence
  irq_master_a: assert property (SUPPLY_IRQ |-> $past(SUPPLY_IRQ_MASTER_EN))
    else $error("irq without master enable");
  rd_hold_a: assert property (!SFR_RD |=> $stable(SFR_RDATA))
    else $error("read data moved without a read");
  pc_read_a: assert property (rd_pc_s |=> pc_word_s)
    else $error("power control readback wrong");
  en_pulse_a: assert property (CORE_CLK_EN |=> !CORE_CLK_EN)
    else $error("core enable longer than one cycle");
  en_cause_a: assert property (CORE_CLK_EN |-> $past(CORE_SRC_TICK))
    else $error("core enable without source tick");
  div_edge_a: assert property ($changed(CORE_CLOCK_DIVIDER) |-> CORE_CLK_EN)
    else $error("divider changed mid period");
  halt_hold_a: assert property (PROCESSOR_SHUTDOWN |=> PROCESSOR_SHUTDOWN)
    else $error("shutdown dropped");
  halt_mode_a: assert property ($rose(PROCESSOR_SHUTDOWN) |-> $past(BATTERY_RUN_MODE))
    else $error("shutdown outside battery run mode");
endmodule : pmsb_bank_asserts

bind pmsb_bank pmsb_bank_asserts #(.CD_WIDTH(CD_WIDTH)) u_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .SFR_ADDR(SFR_ADDR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
  .BATTERY_RUN_MODE(BATTERY_RUN_MODE), .SUPPLY_IRQ_MASTER_EN(SUPPLY_IRQ_MASTER_EN),
  .CORE_SRC_TICK(CORE_SRC_TICK), .METERING_POWER_DOWN(METERING_POWER_DOWN),
  .PROCESSOR_SHUTDOWN(PROCESSOR_SHUTDOWN), .CORE_CLK_EN(CORE_CLK_EN),
  .CORE_CLOCK_DIVIDER(CORE_CLOCK_DIVIDER), .SUPPLY_IRQ(SUPPLY_IRQ)
);

//--- dv/pmsb_core_model.sv
// Purpose: core-side source clock and divided-period meter
// Assumes: bank samples src_tick on the same rising edge
// Notes: the divider changes only at a period end, so the first period after a change is whole
`timescale 1ns/10ps
module pmsb_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // divided enable from the bank
  input wire logic core_clk_en,
  // source tick and last measured period
  output logic src_tick,
  output logic [8:0] ticks_per_pulse
);
  int acc;
  logic [8:0] cnt;
  // fractional accumulator keeps a 4.096 MHz mean rate on 25 MHz
  always @(posedge clk) begin
    if (rst) begin
      acc <= 0;
      src_tick <= 1'b0;
      cnt <= 9'h000;
    end else begin
      acc <= (acc + 4096 >= 25000) ? acc + 4096 - 25000 : acc + 4096;
      src_tick <= (acc + 4096 >= 25000);
      if (core_clk_en) begin
        ticks_per_pulse <= cnt;
        cnt <= 9'h000;
      end else if (src_tick) begin
        cnt <= cnt + 9'h001;
      end
    end
  end
endmodule : pmsb_core_model

//--- dv/pmsb_bank_tb.sv
// Purpose: self-checking bench for the power-management register bank
// Assumes: inputs change on the falling edge
// Notes: scratch values are unknown until written or cleared
`timescale 1ns/10ps
module pmsb_bank_tb
  import pmsb_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic bat_run = 1'b0;
  logic master = 1'b0;
  logic lost = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [7:0] rdata;
  logic tick, meter, halt, clk_en, irq;
  logic [2:0] cd;
  logic [8:0] tpp;
  int errors = 0;
  int num_checks = 0;
  localparam int BITS[6] = '{7, 5, 3, 2, 1, 0};

  always #20 clk = ~clk;

  pmsb_bank DUT (.CLK_SYS(clk), .RESET(rst), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(sfr_wr),
    .SFR_RD(sfr_rd), .SFR_RDATA(rdata), .BATTERY_RUN_MODE(bat_run), .SUPPLY_IRQ_MASTER_EN(master),
    .BOTH_SUPPLIES_LOST(lost), .SUPPLY_EVENT_IN(ev), .CORE_SRC_TICK(tick), .METERING_POWER_DOWN(meter),
    .PROCESSOR_SHUTDOWN(halt), .CORE_CLK_EN(clk_en), .CORE_CLOCK_DIVIDER(cd), .SUPPLY_IRQ(irq));
  pmsb_core_model u_core (.clk(clk), .rst(rst), .core_clk_en(clk_en), .src_tick(tick), .ticks_per_pulse(tpp));

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk({1'b0, rdata}, {1'b0, exp});
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic t_reset;
    rd(PMSB_OFS_IRQ_ENABLE, 8'h00);
    rd(PMSB_OFS_POWER_CONTROL, 8'h82);
    chk({6'h00, cd}, 9'h002);
    rd(8'h00, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_scratch;
    for (int i = 0; i < 4; i++) wr(PMSB_OFS_SCRATCH_A + 8'(i), 8'h3C ^ 8'(i));
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) rd(PMSB_OFS_SCRATCH_A + 8'(i), 8'h3C ^ 8'(i));
    lost = 1'b1;
    cyc(5);
    lost = 1'b0;
    cyc(3);
    for (int i = 0; i < 4; i++) rd(PMSB_OFS_SCRATCH_A + 8'(i), 8'h00);
    $display("test scratch done");
  endtask : t_scratch

  task automatic t_irq;
    master = 1'b1;
    for (int k = 0; k < 6; k++) begin
      wr(PMSB_OFS_IRQ_ENABLE, 8'h01 << BITS[k]);
      ev[BITS[k]] = 1'b1;
      cyc(6);
      chk({8'h00, irq}, 9'h001);
      rd(PMSB_OFS_EVENT_FLAGS, (8'h01 << BITS[k]) | 8'h40);
      wr(PMSB_OFS_EVENT_FLAGS, 8'hFF);
      cyc(3);
      chk({8'h00, irq}, 9'h001);
      wr(PMSB_OFS_EVENT_FLAGS, 8'h00);
      cyc(3);
      chk({8'h00, irq}, 9'h000);
      ev[BITS[k]] = 1'b0;
    end
    wr(PMSB_OFS_IRQ_ENABLE, 8'h00);
    ev = 8'h14;
    cyc(6);
    rd(PMSB_OFS_EVENT_FLAGS, 8'h04);
    chk({8'h00, irq}, 9'h000);
    master = 1'b0;
    wr(PMSB_OFS_IRQ_ENABLE, 8'h04);
    cyc(3);
    chk({8'h00, irq}, 9'h000);
    master = 1'b1;
    cyc(3);
    chk({8'h00, irq}, 9'h001);
    wr(PMSB_OFS_EVENT_FLAGS, 8'h00);
    ev = 8'h00;
    $display("test irq done");
  endtask : t_irq

  task automatic t_power;
    wr(PMSB_OFS_POWER_CONTROL, 8'h40);
    rd(PMSB_OFS_POWER_CONTROL, 8'h82);
    wr(PMSB_OFS_KEY, PMSB_KEY_UNLOCK);
    wr(PMSB_OFS_SCRATCH_A, 8'h00);
    wr(PMSB_OFS_POWER_CONTROL, 8'h40);
    rd(PMSB_OFS_POWER_CONTROL, 8'h82);
    for (int c = 0; c < 8; c++) begin
      wr(PMSB_OFS_KEY, PMSB_KEY_UNLOCK);
      wr(PMSB_OFS_POWER_CONTROL, 8'h40 | 8'(c));
      rd(PMSB_OFS_POWER_CONTROL, 8'hC0 | 8'(c));
      repeat (3) begin
        @(posedge clk_en);
        @(negedge clk);
      end
      chk({6'h00, cd}, 9'(c));
      chk(tpp, 9'h001 << c);
      chk({8'h00, meter}, 9'h001);
    end
    $display("test power control done");
  endtask : t_power

  task automatic t_halt;
    wr(PMSB_OFS_KEY, PMSB_KEY_UNLOCK);
    wr(PMSB_OFS_POWER_CONTROL, 8'h12);
    cyc(4);
    chk({8'h00, halt}, 9'h000);
    bat_run = 1'b1;
    cyc(3);
    chk({8'h00, halt}, 9'h001);
    $display("test shutdown done");
  endtask : t_halt

  initial begin
    cyc(3);
    rst = 1'b0;
    t_reset();
    t_scratch();
    t_irq();
    t_power();
    t_halt();
    test_done();
  end

  // whole run is under ten thousand cycles
  initial begin
    #(40 * 50000);
    errors++;
    test_done();
  end
endmodule : pmsb_bank_tb
